// *** src/slpm_pkg.sv ***
/*
 Package for the safety link parameter monitor: register offsets, reset values,
 field layouts, state encoding and timing constants.
 Assumes a 250 MHz reference clock.
*/
package slpm_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned MS_UNIT = 1;
   localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000 * MS_UNIT;
   localparam logic [15:0] ADDR_MIN = 16'h0001;
   localparam logic [15:0] ADDR_MAX = 16'hfffe;
   localparam logic [13:0] WD_MIN_MS = 14'd50;
   localparam logic [13:0] WD_MAX_MS = 14'd10000;
   localparam logic [13:0] WD_RST_MS = 14'd150;
   localparam logic [15:0] CRC_RST = 16'ha98a;
   localparam logic [15:0] CRC_TEST = 16'h0000;
   localparam logic [15:0] DEST_RST = 16'h0000;
   localparam logic [0:0] FMT_RST = 1'b1;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_DEST = 4'h1;
   localparam logic [3:0] REG_OWN = 4'h2;
   localparam logic [3:0] REG_WD = 4'h3;
   localparam logic [3:0] REG_ECRC = 4'h4;
   localparam logic [3:0] REG_CCRC = 4'h5;
   localparam logic [3:0] REG_STAT = 4'h6;
   localparam logic [3:0] REG_IRQ = 4'h7;
   localparam logic [3:0] REG_MASK = 4'h8;
   localparam int unsigned CTRL_START = 0;
   localparam int unsigned CTRL_FMT = 1;
   localparam int unsigned IRQ_W = 4;
   localparam int unsigned EV_TIMEOUT = 0;
   localparam int unsigned EV_RESTORE = 1;
   localparam int unsigned EV_RUN = 2;
   localparam int unsigned EV_CFGERR = 3;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CHECK = 3'b001,
      ST_RUN = 3'b011,
      ST_TEST = 3'b010,
      ST_SAFE = 3'b110
   } slpm_state_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } slpm_bus_t;
endpackage : slpm_pkg

// *** src/slpm_top.sv ***
/*
 Safety link parameter monitor: address and CRC checks at connection start,
 restore request, test mode and a communication watchdog with latched safe state.
 Assumes all inputs are synchronous to ref_clk; telegram_ok is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module slpm_top
   import slpm_pkg::*;
#(
   parameter int unsigned CYC_MS = CYC_PER_MS
) (
   input wire logic ref_clk, // Reference clock.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic [3:0] reg_addr, // Register word index.
   input wire logic [31:0] reg_wdata, // Write data.
   input wire logic reg_wr, // Write strobe.
   input wire logic reg_rd, // Read strobe.
   output logic [31:0] reg_rdata, // Read data, one cycle after strobe.
   input wire logic [15:0] computed_param_crc, // CRC over stored parameters.
   input wire logic telegram_ok, // Valid telegram received pulse.
   output logic data_exchange, // Safety data exchange permitted.
   output logic test_mode, // Test mode active.
   output logic safe_state, // Safe state latched.
   output logic restore_req, // Restore request pulse to parameter server.
   output logic irq // Interrupt, level.
);
   slpm_bus_t bus;
   slpm_state_t st_q;
   logic start_q;
   logic param_block_format_q;
   logic [15:0] dest_q;
   logic [15:0] own_q;
   logic [13:0] watchdog_interval_param_q;
   logic [15:0] expected_param_crc_q;
   logic [31:0] cyc_q;
   logic [13:0] ms_q;
   logic [IRQ_W-1:0] stat_q;
   logic [IRQ_W-1:0] mask_q;
   logic [IRQ_W-1:0] ev;
   logic addr_ok;
   logic crc_used;
   logic wd_expire;
   logic live;
   logic start_pulse;
   logic stat_rd;

   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign addr_ok = (dest_q >= ADDR_MIN) && (dest_q <= ADDR_MAX);
   assign crc_used = param_block_format_q;
   assign start_pulse = bus.wr && (bus.addr == REG_CTRL) && bus.wdata[CTRL_START];
   assign stat_rd = bus.rd && (bus.addr == REG_IRQ);

   // Configuration registers; out-of-range watchdog writes are clamped.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         start_q <= 1'b0;
         param_block_format_q <= FMT_RST;
         dest_q <= DEST_RST;
         own_q <= DEST_RST;
         watchdog_interval_param_q <= WD_RST_MS;
         expected_param_crc_q <= CRC_RST;
         mask_q <= '0;
      end else if (bus.wr) begin
         unique case (bus.addr)
            REG_CTRL: begin
               start_q <= bus.wdata[CTRL_START];
               param_block_format_q <= bus.wdata[CTRL_FMT];
            end
            REG_DEST: dest_q <= bus.wdata[15:0];
            REG_OWN: own_q <= bus.wdata[15:0];
            REG_WD: begin
               if (bus.wdata[31:0] < 32'(WD_MIN_MS)) begin
                  watchdog_interval_param_q <= WD_MIN_MS;
               end else if (bus.wdata[31:0] > 32'(WD_MAX_MS)) begin
                  watchdog_interval_param_q <= WD_MAX_MS;
               end else begin
                  watchdog_interval_param_q <= bus.wdata[13:0];
               end
            end
            REG_ECRC: expected_param_crc_q <= bus.wdata[15:0];
            REG_MASK: mask_q <= bus.wdata[IRQ_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Link state machine.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_q <= ST_IDLE;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (start_pulse) begin
                  st_q <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               if (!addr_ok || dest_q != own_q) begin
                  st_q <= ST_IDLE;
               end else if (!crc_used) begin
                  st_q <= ST_RUN;
               end else if (expected_param_crc_q == CRC_TEST) begin
                  st_q <= ST_TEST;
               end else if (expected_param_crc_q == computed_param_crc) begin
                  st_q <= ST_RUN;
               end
            end
            // A new start while linked rechecks the configuration first.
            ST_RUN, ST_TEST: begin
               if (wd_expire) begin
                  st_q <= ST_SAFE;
               end else if (start_pulse) begin
                  st_q <= ST_CHECK;
               end
            end
            ST_SAFE: begin
               if (start_pulse) begin
                  st_q <= ST_CHECK;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   assign live = (st_q == ST_RUN) || (st_q == ST_TEST);

   // Watchdog: millisecond prescaler and millisecond counter.
   always_ff @(posedge ref_clk) begin
      if (rst || !live || telegram_ok) begin
         cyc_q <= '0;
         ms_q <= '0;
      end else if (cyc_q == CYC_MS - 1) begin
         cyc_q <= '0;
         ms_q <= ms_q + 14'd1;
      end else begin
         cyc_q <= cyc_q + 32'd1;
      end
   end

   // Compare with >= so that an interval shortened mid-run still expires.
   assign wd_expire = live && !telegram_ok && (ms_q >= watchdog_interval_param_q);

   // Restore request pulses every other cycle while a mismatch is seen in checking.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         restore_req <= 1'b0;
      end else begin
         restore_req <= (st_q == ST_CHECK) && addr_ok && (dest_q == own_q) && crc_used
            && (expected_param_crc_q != CRC_TEST)
            && (expected_param_crc_q != computed_param_crc) && !restore_req;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         data_exchange <= 1'b0;
         test_mode <= 1'b0;
         safe_state <= 1'b0;
      end else begin
         data_exchange <= (st_q == ST_RUN) && !wd_expire;
         test_mode <= (st_q == ST_TEST) && !wd_expire;
         safe_state <= (st_q == ST_SAFE) || wd_expire;
      end
   end

   assign ev[EV_TIMEOUT] = wd_expire;
   assign ev[EV_RESTORE] = restore_req;
   assign ev[EV_RUN] = (st_q == ST_CHECK) && (st_q != ST_RUN) && data_exchange;
   assign ev[EV_CFGERR] = (st_q == ST_CHECK) && (!addr_ok || dest_q != own_q);

   // Sticky status; an event in the clearing read cycle is kept.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stat_q <= '0;
      end else begin
         stat_q <= (stat_rd ? '0 : stat_q) | ev;
      end
   end

   assign irq = |(stat_q & mask_q);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (bus.rd) begin
         unique case (bus.addr)
            REG_CTRL: reg_rdata <= {30'h0, param_block_format_q, start_q};
            REG_DEST: reg_rdata <= {16'h0, dest_q};
            REG_OWN: reg_rdata <= {16'h0, own_q};
            REG_WD: reg_rdata <= {18'h0, watchdog_interval_param_q};
            REG_ECRC: reg_rdata <= crc_used ? {16'h0, expected_param_crc_q} : 32'h0;
            REG_CCRC: reg_rdata <= {16'h0, computed_param_crc};
            REG_STAT: reg_rdata <= {24'h0, addr_ok, 2'h0, st_q, test_mode, safe_state};
            REG_IRQ: reg_rdata <= {28'h0, stat_q};
            REG_MASK: reg_rdata <= {28'h0, mask_q};
            default: reg_rdata <= 32'h0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   a_wd_range: assert property (@(posedge ref_clk) disable iff (rst)
      watchdog_interval_param_q >= WD_MIN_MS && watchdog_interval_param_q <= WD_MAX_MS)
      else $error("watchdog interval out of range");
   a_addr_gate: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == ST_CHECK && dest_q != own_q) |=> st_q == ST_IDLE)
      else $error("start with mismatched address");
   a_addr_range: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == ST_CHECK && dest_q == 16'hffff) |=> st_q == ST_IDLE)
      else $error("start with invalid address");
   a_crc_hold: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(data_exchange) |-> !crc_used || $past(expected_param_crc_q == computed_param_crc, 2))
      else $error("exchange without crc match");
   sequence s_mismatch;
      st_q == ST_CHECK && crc_used && expected_param_crc_q != CRC_TEST
         && expected_param_crc_q != computed_param_crc && addr_ok && dest_q == own_q;
   endsequence
   a_restore_req: assert property (@(posedge ref_clk) disable iff (rst)
      s_mismatch ##1 s_mismatch |-> ##[0:1] restore_req)
      else $error("no restore request on mismatch");
   sequence s_link_ok;
      st_q == ST_CHECK && addr_ok && dest_q == own_q;
   endsequence
   sequence s_test_req;
      s_link_ok ##0 crc_used && expected_param_crc_q == CRC_TEST;
   endsequence
   sequence s_crc_match;
      s_link_ok ##0 crc_used && expected_param_crc_q != CRC_TEST
         && expected_param_crc_q == computed_param_crc;
   endsequence
   a_test_mode: assert property (@(posedge ref_clk) disable iff (rst)
      s_test_req |=> st_q == ST_TEST ##1 test_mode && !data_exchange)
      else $error("test mode entry wrong");
   a_wd_safe: assert property (@(posedge ref_clk) disable iff (rst)
      wd_expire |=> safe_state && !data_exchange && !test_mode)
      else $error("watchdog miss without safe state");
   a_wd_restart: assert property (@(posedge ref_clk) disable iff (rst)
      live && telegram_ok |=> ms_q == 14'd0 && cyc_q == 32'd0)
      else $error("watchdog not restarted");
   a_safe_latch: assert property (@(posedge ref_clk) disable iff (rst)
      st_q == ST_SAFE && !start_pulse |=> st_q == ST_SAFE)
      else $error("safe state not latched");
   a_wd_default: assert property (@(posedge ref_clk)
      $past(rst) |-> watchdog_interval_param_q == WD_RST_MS && expected_param_crc_q == CRC_RST)
      else $error("bad reset defaults");

   // Connection start and address screening.
   a_start_idle: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == ST_IDLE && start_pulse) |=> st_q == ST_CHECK)
      else $error("start not taken");
   a_addr_bad: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == ST_CHECK && !addr_ok) |=> st_q == ST_IDLE)
      else $error("invalid address accepted");
   a_cfg_stat: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == ST_CHECK && !addr_ok) |=> stat_q[EV_CFGERR])
      else $error("config error not flagged");
   a_idle_quiet: assert property (@(posedge ref_clk) disable iff (rst)
      st_q == ST_IDLE |-> !data_exchange && !test_mode && !safe_state)
      else $error("outputs active while idle");

   // Parameter CRC comparison and restore requests.
   a_check_quiet: assert property (@(posedge ref_clk) disable iff (rst)
      st_q == ST_CHECK |=> !data_exchange && !test_mode)
      else $error("exchange during check");
   a_mismatch_hold: assert property (@(posedge ref_clk) disable iff (rst)
      s_mismatch |=> st_q == ST_CHECK)
      else $error("left check on mismatch");
   a_match_run: assert property (@(posedge ref_clk) disable iff (rst)
      s_crc_match |=> st_q == ST_RUN)
      else $error("no run on crc match");
   a_fmt_skip: assert property (@(posedge ref_clk) disable iff (rst)
      (s_link_ok ##0 !crc_used) |=> st_q == ST_RUN)
      else $error("format zero not run");
   a_ecrc_hidden: assert property (@(posedge ref_clk) disable iff (rst)
      (bus.rd && bus.addr == REG_ECRC && !crc_used) |=> reg_rdata == 32'h0)
      else $error("crc shown in format zero");
   a_restore_only: assert property (@(posedge ref_clk) disable iff (rst)
      restore_req |-> $past(st_q == ST_CHECK))
      else $error("restore outside check");
   a_restore_stat: assert property (@(posedge ref_clk) disable iff (rst)
      restore_req |=> stat_q[EV_RESTORE])
      else $error("restore not flagged");

   // Watchdog interval programming and counting.
   a_wd_clamp_lo: assert property (@(posedge ref_clk) disable iff (rst)
      (bus.wr && bus.addr == REG_WD && bus.wdata < 32'(WD_MIN_MS))
         |=> watchdog_interval_param_q == WD_MIN_MS)
      else $error("low interval not clamped");
   a_wd_clamp_hi: assert property (@(posedge ref_clk) disable iff (rst)
      (bus.wr && bus.addr == REG_WD && bus.wdata > 32'(WD_MAX_MS))
         |=> watchdog_interval_param_q == WD_MAX_MS)
      else $error("high interval not clamped");
   a_wd_hold: assert property (@(posedge ref_clk) disable iff (rst)
      (live && !telegram_ok && cyc_q != CYC_MS - 1) |=> $stable(ms_q))
      else $error("millisecond count moved early");
   a_wd_tick: assert property (@(posedge ref_clk) disable iff (rst)
      (live && !telegram_ok && cyc_q == CYC_MS - 1) |=> ms_q == $past(ms_q) + 14'd1)
      else $error("millisecond count missed");

   // Safe state entry, latching and leaving.
   a_wd_exit: assert property (@(posedge ref_clk) disable iff (rst)
      wd_expire |=> st_q == ST_SAFE)
      else $error("watchdog miss kept link");
   a_timeout_stat: assert property (@(posedge ref_clk) disable iff (rst)
      wd_expire |=> stat_q[EV_TIMEOUT])
      else $error("timeout not flagged");
   a_safe_exit: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == ST_SAFE && start_pulse) |=> st_q == ST_CHECK)
      else $error("safe state not left on start");
   a_safe_hold: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == ST_SAFE && !start_pulse) |=> safe_state)
      else $error("safe output dropped");

   // Exchange and test outputs while linked.
   a_run_exchange: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == ST_RUN && !wd_expire) |=> data_exchange)
      else $error("no exchange while running");
   a_test_quiet: assert property (@(posedge ref_clk) disable iff (rst)
      test_mode |-> !data_exchange)
      else $error("exchange in test mode");
   a_run_restart: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == ST_RUN && start_pulse && !wd_expire) |=> st_q == ST_CHECK)
      else $error("running link not rechecked");
   a_test_restart: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == ST_TEST && start_pulse && !wd_expire) |=> st_q == ST_CHECK)
      else $error("test link not rechecked");

endmodule : slpm_top
`default_nettype wire

// *** tb/slpm_ctrl_model.sv ***
/*
 Controller-side model: sends one valid telegram pulse every period cycles while enabled.
 Assumes the bench clock and its synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module slpm_ctrl_model (
   input wire logic ref_clk, // Clock.
   input wire logic rst, // Reset, active high.
   input wire logic en, // Telegram traffic on.
   input wire logic [15:0] period, // Cycles between telegrams.
   output logic telegram_ok // Valid telegram pulse.
);
   logic [15:0] cnt_q;
   always_ff @(posedge ref_clk) begin
      if (rst || !en) begin
         cnt_q <= 16'h0000;
         telegram_ok <= 1'b0;
      end else begin
         telegram_ok <= (cnt_q == period - 16'h0001);
         cnt_q <= (cnt_q == period - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
      end
   end
endmodule : slpm_ctrl_model
`default_nettype wire

// *** tb/testbench.sv ***
/*
 Self-checking bench for the safety link parameter monitor.
 Assumes one millisecond is shortened to four clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import slpm_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [15:0] ccrc = 16'ha98a;
   logic tg, dx, tm, ss, rq, irq;
   logic tg_en = 1'b1;
   int n_errors = 0;
   int n_compared = 0;
   int n_rest = 0;
   int cyc = 0;
   always #2 ref_clk = ~ref_clk;
   slpm_top #(.CYC_MS(4)) dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .computed_param_crc(ccrc), .telegram_ok(tg), .data_exchange(dx), .test_mode(tm),
      .safe_state(ss), .restore_req(rq), .irq(irq));
   slpm_ctrl_model partner (.ref_clk(ref_clk), .rst(rst), .en(tg_en), .period(16'd100),
      .telegram_ok(tg));
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (rq === 1'b1) n_rest <= n_rest + 1;
      if (cyc == 20000) begin
         n_errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic start(input logic [15:0] dst, input logic [15:0] own, input logic [31:0] c);
      wr(REG_DEST, {16'h0, dst});
      wr(REG_OWN, {16'h0, own});
      wr(REG_CTRL, c);
      repeat (4) @(posedge ref_clk);
      #1;
   endtask : start
   task automatic t_regs();
      logic [31:0] v;
      rd(REG_WD, v); chk(v, 32'd150, "wd reset");
      rd(REG_ECRC, v); chk(v, 32'h0000a98a, "crc reset");
      rd(4'hf, v); chk(v, 32'h0, "unmapped");
      wr(REG_WD, 32'd10); rd(REG_WD, v); chk(v, 32'd50, "wd low");
      wr(REG_WD, 32'd20000); rd(REG_WD, v); chk(v, 32'd10000, "wd high");
   endtask : t_regs
   task automatic t_addr();
      start(16'h0000, 16'h0000, 32'h3); chk(dx, 1'b0, "addr zero");
      start(16'hffff, 16'hffff, 32'h3); chk(dx, 1'b0, "addr max");
      start(16'h0005, 16'h0006, 32'h3); chk(dx, 1'b0, "addr differ");
      start(16'hfffe, 16'hfffe, 32'h3); chk(dx, 1'b1, "addr top ok");
   endtask : t_addr
   task automatic t_crc();
      logic [31:0] v;
      int n0;
      ccrc <= 16'h4321;
      wr(REG_ECRC, 32'h1234);
      wr(REG_MASK, 32'h2);
      n0 = n_rest;
      start(16'h0009, 16'h0009, 32'h3);
      chk(dx, 1'b0, "crc hold");
      chk(n_rest > n0, 1'b1, "no restore");
      chk(irq, 1'b1, "restore irq");
      rd(REG_IRQ, v); chk(v[1], 1'b1, "restore bit");
      wr(REG_ECRC, {16'h0, ccrc});
      start(16'h0009, 16'h0009, 32'h3); chk(dx, 1'b1, "crc run");
      rd(REG_IRQ, v);
      @(posedge ref_clk); #1 chk(irq, 1'b0, "irq clear");
      wr(REG_ECRC, 32'h0);
      start(16'h0009, 16'h0009, 32'h3); chk({tm, dx}, 2'b10, "test mode");
      wr(REG_CTRL, 32'h0); rd(REG_ECRC, v); chk(v, 32'h0, "fmt0 crc");
      start(16'h0009, 16'h0009, 32'h1); chk({tm, dx}, 2'b01, "fmt0 run");
   endtask : t_crc
   task automatic t_wd();
      logic [31:0] v;
      wr(REG_WD, 32'd50);
      wr(REG_MASK, 32'h1);
      start(16'h0009, 16'h0009, 32'h1);
      repeat (600) @(posedge ref_clk);
      #1 chk({ss, dx}, 2'b01, "wd kept");
      @(posedge ref_clk iff tg);
      tg_en <= 1'b0;
      repeat (190) @(posedge ref_clk);
      #1 chk(ss, 1'b0, "wd early");
      repeat (25) @(posedge ref_clk);
      #1 chk({ss, dx}, 2'b10, "wd miss");
      chk(irq, 1'b1, "wd irq");
      rd(REG_IRQ, v); chk(v[0], 1'b1, "wd bit");
      tg_en <= 1'b1;
      repeat (300) @(posedge ref_clk);
      #1 chk(ss, 1'b1, "safe latch");
      start(16'h0009, 16'h0009, 32'h1); chk({ss, dx}, 2'b01, "restart");
   endtask : t_wd
   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs();
      t_addr();
      t_crc();
      t_wd();
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
